//--- design/wds_map.svh
`ifndef WDS_MAP_SVH
`define WDS_MAP_SVH
// timing
`define WDS_CLK_MHZ          100
`define WDS_HB_STEP_US       1600
`define WDS_SSOT_MIN         20
`define WDS_US_PER_MIN       60_000_000
`define WDS_RST_TIME_US      10
// register byte offsets
`define WDS_OFF_TEC_CFG      8'h00
`define WDS_OFF_TEC_STAT     8'h04
`define WDS_OFF_SUP_CFG      8'h08
`define WDS_OFF_SUP_STAT_A   8'h0C
`define WDS_OFF_SUP_STAT_B   8'h10
`define WDS_OFF_CMD          8'h14
`define WDS_OFF_HB_CFG       8'h18
`define WDS_OFF_HB_SYNC      8'h1C
`define WDS_OFF_PRE_SAMPLE   8'h20
`define WDS_OFF_HB_SAMPLE    8'h24
// fields
`define WDS_F_TEC_INC        5:0
`define WDS_F_TEC_DEC        13:8
`define WDS_F_CNT            5:0
`define WDS_F_WD_REN         0
`define WDS_F_LO3            2:0
`define WDS_F_HI3            6:4
`define WDS_F_READY          8
`define WDS_F_SAFE           9
`define WDS_F_PWRDN          10
`define WDS_F_SSOT_RUN       11
`define WDS_F_SAMPLE         0
`define WDS_F_PERIOD         6:0
`define WDS_F_PRE            17:0
// reset values and limits
`define WDS_TEC_INC_RST      6'h01
`define WDS_TEC_DEC_RST      6'h01
`define WDS_REN_RST          1'b1
`define WDS_HB_PERIOD_RST    7'h0A
`define WDS_SAFE_LIMIT       6'h20
`define WDS_RSTC_FULL        3'h7
`define WDS_PDC_FULL         3'h7
`endif

//--- design/wds_pkg.sv
package wds_pkg;
	typedef enum logic [1:0]
	{
		WDS_EC_IDLE = 2'b01,
		WDS_EC_ERR  = 2'b10
	} wds_ec_t;
	typedef logic [5:0] wds_cnt_t;
	typedef logic [2:0] wds_small_t;
endpackage : wds_pkg

//--- design/wds_top.sv
`timescale 1ns/1ns
`include "wds_map.svh"
module wds_top #(
	parameter logic [17:0] PREDIV_CYCLES = 18'(`WDS_HB_STEP_US * `WDS_CLK_MHZ),
	parameter logic [39:0] SSOT_CYCLES   =
		40'(64'(`WDS_SSOT_MIN) * 64'(`WDS_US_PER_MIN) * 64'(`WDS_CLK_MHZ))
) (
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_window_error,
	input  wire logic        i_resp_byte0,
	input  wire logic        i_resp_sync_byte0,
	input  wire logic        i_resp_wrong,
	input  wire logic [5:0]  i_window_error_count,
	input  wire logic [5:0]  i_func_pass_count,
	input  wire logic        i_window_overflow,
	input  wire logic        i_func_overflow,
	input  wire logic        i_soft_reset,
	input  wire logic        i_key,
	output logic             o_base_tick,
	output logic             o_hb_event,
	output logic             o_monitor_clear,
	output logic             o_wd_rst_n,
	output logic             o_safety_ok_pin,
	output logic             o_actuator_off,
	output logic             o_power_down
);
	localparam logic [11:0] RST_HOLD = 12'(`WDS_RST_TIME_US * `WDS_CLK_MHZ);

	// ==========================================================
	// reset release
	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ==========================================================
	// apb slave
	wds_pkg::wds_cnt_t   tec_inc, tec_dec, next_tec_inc, next_tec_dec;
	logic                wd_reset_en, next_wd_reset_en;
	logic [6:0]          hb_period, next_hb_period;
	logic [17:0]         pre_sample, next_pre_sample;
	logic [6:0]          hb_sample, next_hb_sample;
	logic [31:0]         next_prdata;
	logic                next_pready, next_pslverr;
	logic                wr_en, hb_sync_wr, hb_cfg_wr, sample_wr;
	logic [6:0]          wr_period;
	wds_pkg::wds_cnt_t   total_error_count;
	wds_pkg::wds_small_t rstc;
	wds_pkg::wds_small_t pdc [3];
	logic [2:0]          pd_ovf;
	logic                ready, ssot_run;
	logic [17:0]         prediv_cnt;
	logic [6:0]          hb_cnt;

	// writes land on the access cycle that carries pready
	assign wr_en      = i_psel & i_penable & i_pwrite & o_pready;
	assign wr_period  = i_pwdata[`WDS_F_PERIOD];
	assign hb_sync_wr = wr_en & (i_paddr == `WDS_OFF_HB_SYNC);
	assign hb_cfg_wr  = wr_en & (i_paddr == `WDS_OFF_HB_CFG);
	assign sample_wr  = wr_en & (i_paddr == `WDS_OFF_CMD) & i_pwdata[`WDS_F_SAMPLE];

	always_comb
	begin
		next_prdata      = 32'h0000_0000;
		next_pready      = 1'b0;
		next_pslverr     = 1'b0;
		next_tec_inc     = tec_inc;
		next_tec_dec     = tec_dec;
		next_wd_reset_en = wd_reset_en;
		next_hb_period   = hb_period;
		next_pre_sample  = pre_sample;
		next_hb_sample   = hb_sample;
		if (i_psel && !i_penable)
		begin
			next_pready = 1'b1;
			case (i_paddr)
				`WDS_OFF_TEC_CFG:
				begin
					next_prdata[`WDS_F_TEC_INC] = tec_inc;
					next_prdata[`WDS_F_TEC_DEC] = tec_dec;
				end
				`WDS_OFF_TEC_STAT:   next_prdata[`WDS_F_CNT] = total_error_count;
				`WDS_OFF_SUP_CFG:    next_prdata[`WDS_F_WD_REN] = wd_reset_en;
				`WDS_OFF_SUP_STAT_A:
				begin
					next_prdata[`WDS_F_LO3] = rstc;
					next_prdata[`WDS_F_HI3] = pdc[0];
				end
				`WDS_OFF_SUP_STAT_B:
				begin
					next_prdata[`WDS_F_LO3]      = pdc[1];
					next_prdata[`WDS_F_HI3]      = pdc[2];
					next_prdata[`WDS_F_READY]    = ready;
					next_prdata[`WDS_F_SAFE]     = ~ready;
					next_prdata[`WDS_F_PWRDN]    = o_power_down;
					next_prdata[`WDS_F_SSOT_RUN] = ssot_run;
				end
				`WDS_OFF_CMD:        next_prdata = 32'h0000_0000;
				`WDS_OFF_HB_CFG:     next_prdata[`WDS_F_PERIOD] = hb_period;
				`WDS_OFF_HB_SYNC:    next_prdata = 32'h0000_0000;
				`WDS_OFF_PRE_SAMPLE: next_prdata[`WDS_F_PRE] = pre_sample;
				`WDS_OFF_HB_SAMPLE:  next_prdata[`WDS_F_PERIOD] = hb_sample;
				default:             next_pslverr = 1'b1;
			endcase
		end
		if (wr_en && i_paddr == `WDS_OFF_TEC_CFG)
		begin
			next_tec_inc = i_pwdata[`WDS_F_TEC_INC];
			next_tec_dec = i_pwdata[`WDS_F_TEC_DEC];
		end
		if (wr_en && i_paddr == `WDS_OFF_SUP_CFG)
			next_wd_reset_en = i_pwdata[`WDS_F_WD_REN];
		// a zero period leaves the running period untouched
		if ((hb_cfg_wr || hb_sync_wr) && wr_period != 7'h00)
			next_hb_period = wr_period;
		if (sample_wr)
		begin
			next_pre_sample = prediv_cnt;
			next_hb_sample  = hb_cnt;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			o_prdata    <= 32'h0000_0000;
			o_pready    <= 1'b0;
			o_pslverr   <= 1'b0;
			tec_inc     <= `WDS_TEC_INC_RST;
			tec_dec     <= `WDS_TEC_DEC_RST;
			wd_reset_en <= `WDS_REN_RST;
			hb_period   <= `WDS_HB_PERIOD_RST;
			pre_sample  <= 18'h0_0000;
			hb_sample   <= 7'h00;
		end
		else
		begin
			o_prdata    <= next_prdata;
			o_pready    <= next_pready;
			o_pslverr   <= next_pslverr;
			tec_inc     <= next_tec_inc;
			tec_dec     <= next_tec_dec;
			wd_reset_en <= next_wd_reset_en;
			hb_period   <= next_hb_period;
			pre_sample  <= next_pre_sample;
			hb_sample   <= next_hb_sample;
		end
	end

	// ==========================================================
	// clock base and heartbeat timer
	logic [17:0] next_prediv_cnt;
	logic [6:0]  next_hb_cnt;
	logic        base_tick, hb_expire, hb_event;

	assign base_tick = (prediv_cnt == PREDIV_CYCLES - 18'h0_0001);
	assign hb_expire = base_tick & (hb_cnt + 7'h01 >= hb_period);
	assign hb_event  = hb_expire | hb_sync_wr | i_resp_sync_byte0 |
		(hb_cfg_wr & wr_period != 7'h00 & hb_cnt >= wr_period);

	always_comb
	begin
		next_prediv_cnt = base_tick ? 18'h0_0000 : prediv_cnt + 18'h0_0001;
		next_hb_cnt     = hb_cnt;
		if (hb_event)
			next_hb_cnt = 7'h00;
		else if (base_tick)
			next_hb_cnt = hb_cnt + 7'h01;
		// sync restarts the whole base so the new period runs from here
		if (hb_sync_wr)
			next_prediv_cnt = 18'h0_0000;
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prediv_cnt  <= 18'h0_0000;
			hb_cnt      <= 7'h00;
			o_base_tick <= 1'b0;
			o_hb_event  <= 1'b0;
		end
		else
		begin
			prediv_cnt  <= next_prediv_cnt;
			hb_cnt      <= next_hb_cnt;
			o_base_tick <= base_tick;
			o_hb_event  <= hb_event;
		end
	end

	// ==========================================================
	// error check and total error counter
	wds_pkg::wds_ec_t  ec_state, next_ec_state;
	wds_pkg::wds_cnt_t next_tec;
	logic              func_error, any_error, tec_up, tec_down, tec_ovf;
	logic [6:0]        tec_sum;
	logic              wd_cond;

	assign func_error = ((i_resp_byte0 | i_resp_sync_byte0) & i_resp_wrong) | hb_sync_wr;
	assign any_error  = func_error | i_window_error;
	assign tec_sum    = {1'b0, total_error_count} + {1'b0, tec_inc};
	assign tec_ovf    = tec_up & tec_sum[6];
	assign wd_cond    = tec_ovf | i_window_overflow | i_func_overflow;

	always_comb
	begin
		next_ec_state = ec_state;
		tec_up        = 1'b0;
		tec_down      = 1'b0;
		next_tec      = total_error_count;
		if (hb_sync_wr)
		begin
			tec_up        = 1'b1;
			next_ec_state = wds_pkg::WDS_EC_IDLE;
		end
		else if (i_resp_sync_byte0)
		begin
			if (any_error || ec_state == wds_pkg::WDS_EC_ERR)
				tec_up = 1'b1;
			else
				tec_down = 1'b1;
			next_ec_state = wds_pkg::WDS_EC_IDLE;
		end
		else
		begin
			case (ec_state)
				wds_pkg::WDS_EC_IDLE:
					if (any_error)
						next_ec_state = wds_pkg::WDS_EC_ERR;
				wds_pkg::WDS_EC_ERR:
					if (hb_event)
					begin
						tec_up        = 1'b1;
						next_ec_state = any_error ? wds_pkg::WDS_EC_ERR
						                          : wds_pkg::WDS_EC_IDLE;
					end
				default: next_ec_state = wds_pkg::WDS_EC_IDLE;
			endcase
		end
		if (tec_up && !tec_sum[6])
			next_tec = tec_sum[5:0];
		else if (tec_down && total_error_count >= tec_dec)
			next_tec = total_error_count - tec_dec;
		if (wd_cond)
			next_tec = 6'h00;
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ec_state        <= wds_pkg::WDS_EC_IDLE;
			total_error_count             <= 6'h00;
			o_monitor_clear <= 1'b0;
		end
		else
		begin
			ec_state        <= next_ec_state;
			total_error_count             <= next_tec;
			o_monitor_clear <= wd_cond;
		end
	end

	// ==========================================================
	// reset counter, reset pulse, state outputs
	wds_pkg::wds_small_t next_rstc;
	logic [11:0]         rst_cnt, next_rst_cnt;
	logic                ready_q, ready_rise, next_ready;

	assign next_ready = (i_window_error_count <= `WDS_SAFE_LIMIT) &
		(i_func_pass_count <= `WDS_SAFE_LIMIT) & (total_error_count <= `WDS_SAFE_LIMIT);
	assign ready      = ready_q;
	assign ready_rise = next_ready & ~ready_q;

	always_comb
	begin
		next_rstc    = rstc;
		next_rst_cnt = (rst_cnt != 12'h000) ? rst_cnt - 12'h001 : rst_cnt;
		// full scale or disabled: no count and no reset pulse
		if (wd_cond && wd_reset_en && rstc != `WDS_RSTC_FULL)
		begin
			next_rstc    = rstc + 3'h1;
			next_rst_cnt = RST_HOLD;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rstc            <= 3'h0;
			rst_cnt         <= 12'h000;
			ready_q         <= 1'b0;
			o_wd_rst_n      <= 1'b1;
			o_safety_ok_pin <= 1'b0;
			o_actuator_off  <= 1'b1;
		end
		else
		begin
			rstc            <= next_rstc;
			rst_cnt         <= next_rst_cnt;
			ready_q         <= next_ready;
			o_wd_rst_n      <= (next_rst_cnt == 12'h000);
			o_safety_ok_pin <= next_ready & (next_rst_cnt == 12'h000);
			o_actuator_off  <= ~next_ready | (next_rst_cnt != 12'h000);
		end
	end

	// ==========================================================
	// power-down counters: window, functional, total error
	logic [2:0] pd_src;
	assign pd_src = {tec_ovf, i_func_overflow, i_window_overflow};

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++)
		begin : g_pdc
			wds_pkg::wds_small_t next_pdc;
			logic                next_ovf, trig;
			assign trig = pd_src[gi] | i_soft_reset;
			always_comb
			begin
				next_pdc = pdc[gi];
				next_ovf = pd_ovf[gi];
				if (ready_rise)
				begin
					next_pdc = 3'h0;
					next_ovf = 1'b0;
				end
				// a trigger in the clearing cycle still counts unless the counter was full, where it sets overflow instead
				if (trig)
				begin
					if (pdc[gi] == `WDS_PDC_FULL)
						next_ovf = 1'b1;
					else
						next_pdc = (ready_rise ? 3'h0 : pdc[gi]) + 3'h1;
				end
			end
			always_ff @(posedge i_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					pdc[gi]    <= 3'h0;
					pd_ovf[gi] <= 1'b0;
				end
				else
				begin
					pdc[gi]    <= next_pdc;
					pd_ovf[gi] <= next_ovf;
				end
			end
		end
	endgenerate

	// ==========================================================
	// secure shut-off timer and power-down
	logic [39:0] ssot_cnt, next_ssot_cnt;
	logic        ssot_done, next_ssot_run, next_ssot_done;

	always_comb
	begin
		next_ssot_cnt  = ssot_cnt;
		next_ssot_run  = ssot_run;
		next_ssot_done = ssot_done;
		if (i_key)
		begin
			next_ssot_cnt  = 40'h00_0000_0000;
			next_ssot_run  = 1'b0;
			next_ssot_done = 1'b0;
		end
		else if (ssot_run)
		begin
			if (ssot_cnt == SSOT_CYCLES - 40'h00_0000_0001)
			begin
				next_ssot_done = 1'b1;
				next_ssot_run  = 1'b0;
			end
			else
				next_ssot_cnt = ssot_cnt + 40'h00_0000_0001;
		end
		else if (wd_cond && !ssot_done)
			next_ssot_run = 1'b1;
	end

	always_ff @(posedge i_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ssot_cnt     <= 40'h00_0000_0000;
			ssot_run     <= 1'b0;
			ssot_done    <= 1'b0;
			o_power_down <= 1'b0;
		end
		else
		begin
			ssot_cnt     <= next_ssot_cnt;
			ssot_run     <= next_ssot_run;
			ssot_done    <= next_ssot_done;
			o_power_down <= ~i_key & ((|pd_ovf) | next_ssot_done);
		end
	end

endmodule : wds_top

//--- bench/wds_checker.sv
`timescale 1ns/1ns
module wds_checker #(
	parameter logic [17:0] PREDIV_CYCLES = 18'h0010,
	parameter logic [39:0] SSOT_CYCLES   = 40'h00C8
) (
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] o_prdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_window_overflow,
	input wire logic        i_resp_sync_byte0,
	input wire logic [5:0]  i_window_error_count,
	input wire logic        i_key,
	input wire logic        o_base_tick,
	input wire logic        o_hb_event,
	input wire logic        o_monitor_clear,
	input wire logic        o_wd_rst_n,
	input wire logic        o_safety_ok_pin,
	input wire logic        o_actuator_off,
	input wire logic        o_power_down
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// ==========================================
	// register bus
	sequence s_setup;
		i_psel && !i_penable;
	endsequence
	a_apb_ready: assert property (s_setup |=> o_pready)
		else $error("pready missing after setup");
	a_bad_addr: assert property ((s_setup ##0 (i_paddr > 8'h24)) |=>
		(o_pslverr && o_prdata == 32'h0000_0000))
		else $error("unmapped access not refused");
	// ==========================================
	// states and pins
	a_key_holds: assert property (i_key ##1 i_key |-> !o_power_down)
		else $error("power down with key high");
	a_safe_state: assert property ((i_window_error_count > 6'h20)[*3] |->
		(o_actuator_off && !o_safety_ok_pin))
		else $error("safe state not shown");
	a_ready_excl: assert property (o_safety_ok_pin |-> !o_actuator_off)
		else $error("ready and safe at once");
	a_rst_pins: assert property ($fell(o_wd_rst_n) |-> ##[0:1]
		(o_actuator_off && !o_safety_ok_pin))
		else $error("monitor high during reset");
	a_rst_hold: assert property ($fell(o_wd_rst_n) |=> !o_wd_rst_n[*8])
		else $error("reset pulse too short");
	a_ovf_clear: assert property (i_window_overflow |-> ##[1:2] o_monitor_clear)
		else $error("overflow did not clear counters");
	a_sync_hb: assert property (i_resp_sync_byte0 |=> o_hb_event)
		else $error("no heartbeat after sync response");
	// the tick spacing is far above eight for any sane divider
	a_tick_gap: assert property (o_base_tick |=> !o_base_tick[*8])
		else $error("base tick too frequent");
endmodule : wds_checker
bind wds_top wds_checker #(.PREDIV_CYCLES(PREDIV_CYCLES), .SSOT_CYCLES(SSOT_CYCLES)) u_chk (
	.i_clk, .i_rst_n, .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready, .o_pslverr,
	.i_window_overflow, .i_resp_sync_byte0, .i_window_error_count, .i_key, .o_base_tick,
	.o_hb_event, .o_monitor_clear, .o_wd_rst_n, .o_safety_ok_pin, .o_actuator_off,
	.o_power_down
);

//--- bench/wds_host.sv
`timescale 1ns/1ns
`include "wds_map.svh"
module wds_host (
	input  wire logic        i_clk,
	input  wire logic [31:0] i_prdata,
	input  wire logic        i_pready,
	input  wire logic        i_pslverr,
	output logic             o_psel,
	output logic             o_penable,
	output logic             o_pwrite,
	output logic      [7:0]  o_paddr,
	output logic      [31:0] o_pwdata
);
	int tmo = 0;
	initial
	begin
		o_psel    = 1'b0;
		o_penable = 1'b0;
		o_pwrite  = 1'b0;
		o_paddr   = 8'h00;
		o_pwdata  = 32'h0000_0000;
	end
	// ==========================================
	// one transfer; the idle edge first keeps two releases apart
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int n;
		n = 0;
		@(posedge i_clk);
		o_psel    <= 1'b1;
		o_penable <= 1'b0;
		o_pwrite  <= w;
		o_paddr   <= a;
		o_pwdata  <= d;
		@(posedge i_clk);
		o_penable <= 1'b1;
		@(posedge i_clk);
		while (i_pready !== 1'b1 && n < 64)
		begin
			n++;
			@(posedge i_clk);
		end
		if (n == 64)
			tmo++;
		q = i_prdata;
		e = i_pslverr;
		o_psel    <= 1'b0;
		o_penable <= 1'b0;
	endtask : xfer
	// two samples let the host scale its own window timing
	task sample(output logic [31:0] pre, output logic [31:0] hb);
		logic [31:0] q;
		logic        e;
		xfer(1'b1, `WDS_OFF_CMD, 32'h0000_0001, q, e);
		xfer(1'b0, `WDS_OFF_PRE_SAMPLE, 32'h0000_0000, pre, e);
		xfer(1'b0, `WDS_OFF_HB_SAMPLE, 32'h0000_0000, hb, e);
	endtask : sample
endmodule : wds_host

//--- bench/wds_top_bench.sv
`timescale 1ns/1ns
`include "wds_map.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s expected %h seen %h", nm, e, s); end end
module wds_top_bench;
	logic        i_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic [4:0]  pv = 5'h00;
	logic        i_resp_wrong = 1'b0;
	logic        i_key = 1'b0;
	logic [5:0]  i_window_error_count = 6'h00;
	logic [5:0]  i_func_pass_count = 6'h00;
	logic        i_resp_byte0 = 1'b0;
	wire         i_window_error, i_resp_sync_byte0, i_window_overflow;
	wire         i_func_overflow, i_soft_reset, i_psel, i_penable, i_pwrite;
	wire  [7:0]  i_paddr;
	wire  [31:0] i_pwdata, o_prdata;
	wire         o_pready, o_pslverr, o_base_tick, o_hb_event, o_monitor_clear;
	wire         o_wd_rst_n, o_safety_ok_pin, o_actuator_off, o_power_down;
	int          bad_count = 0;
	int          n_compared = 0;
	assign {i_soft_reset, i_func_overflow, i_window_overflow, i_resp_sync_byte0,
		i_window_error} = pv;
	always #5 i_clk = ~i_clk;
	wds_top #(.PREDIV_CYCLES(18'h0010), .SSOT_CYCLES(40'h00C8)) dut (
		.i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
		.o_pready, .o_pslverr, .i_window_error, .i_resp_byte0, .i_resp_sync_byte0,
		.i_resp_wrong, .i_window_error_count, .i_func_pass_count, .i_window_overflow,
		.i_func_overflow, .i_soft_reset, .i_key, .o_base_tick, .o_hb_event, .o_monitor_clear,
		.o_wd_rst_n, .o_safety_ok_pin, .o_actuator_off, .o_power_down
	);
	wds_host host (
		.i_clk, .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr),
		.o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
		.o_pwdata(i_pwdata)
	);
	// ==========================================
	// helpers
	task give_verdict;
		bad_count += host.tmo;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : give_verdict
	task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		logic        er;
		host.xfer(1'b0, a, 32'h0000_0000, q, er);
		`CHK($sformatf("reg_%h", a), e, q & m)
	endtask : rd
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        er;
		host.xfer(1'b1, a, d, q, er);
	endtask : wr
	task pulse(input logic [4:0] v);
		pv <= v;
		@(posedge i_clk);
		pv <= 5'h00;
		@(posedge i_clk);
	endtask : pulse
	// bounded wait for heartbeat (0) or reset release (1)
	task await(input logic w);
		int n;
		n = 0;
		while ((w ? o_wd_rst_n : o_hb_event) !== 1'b1 && n < 1500)
		begin
			n++;
			@(posedge i_clk);
		end
		if (n == 1500)
		begin
			bad_count++;
			give_verdict();
		end
	endtask : await
	// a hung bus transfer ends the run at once, without waiting for the 60000-cycle global limit
	initial
	begin
		for (int k = 0; k < 60000 && host.tmo == 0; k++)
			@(posedge i_clk);
		bad_count++;
		give_verdict();
	end
	// ==========================================
	// main sequence
	initial
	begin
		logic [31:0] q;
		logic [31:0] h;
		logic        er;
		repeat (12) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(`WDS_OFF_TEC_CFG, 32'hFFFF_FFFF, 32'h0000_0101);
		rd(`WDS_OFF_SUP_CFG, 32'hFFFF_FFFF, 32'h0000_0001);
		rd(`WDS_OFF_HB_CFG, 32'hFFFF_FFFF, 32'h0000_000A);
		host.xfer(1'b0, 8'h28, 32'h0000_0000, q, er);
		`CHK("unmapped_err", 1'b1, er)
		wr(`WDS_OFF_TEC_CFG, 32'h0000_0203);
		wr(`WDS_OFF_TEC_STAT, 32'h0000_003F);
		rd(`WDS_OFF_TEC_CFG, 32'hFFFF_FFFF, 32'h0000_0203);
		pulse(5'h02);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
		wr(`WDS_OFF_HB_SYNC, 32'h0000_0000);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0003);
		pulse(5'h02);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0001);
		pulse(5'h02);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0001);
		i_resp_wrong <= 1'b1;
		pulse(5'h02);
		i_resp_wrong <= 1'b0;
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0004);
		pulse(5'h01);
		await(1'b0);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0007);
		// a wrong plain response also waits for the next heartbeat
		i_resp_wrong <= 1'b1;
		i_resp_byte0 <= 1'b1;
		@(posedge i_clk);
		i_resp_wrong <= 1'b0;
		i_resp_byte0 <= 1'b0;
		await(1'b0);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_000A);
		// overflow sources feed reset and power-down counters
		pulse(5'h04);
		repeat (3) @(posedge i_clk);
		`CHK("wd_rst_n", 1'b0, o_wd_rst_n)
		rd(`WDS_OFF_SUP_STAT_A, 32'h0000_0077, 32'h0000_0011);
		rd(`WDS_OFF_TEC_STAT, 32'hFFFF_FFFF, 32'h0000_0000);
		`CHK("power_down", 1'b0, o_power_down)
		pulse(5'h08);
		rd(`WDS_OFF_SUP_STAT_A, 32'h0000_0077, 32'h0000_0012);
		pulse(5'h10);
		rd(`WDS_OFF_SUP_STAT_A, 32'h0000_0077, 32'h0000_0022);
		rd(`WDS_OFF_SUP_STAT_B, 32'h0000_0377, 32'h0000_0112);
		await(1'b1);
		`CHK("power_down", 1'b1, o_power_down)
		wr(`WDS_OFF_SUP_CFG, 32'h0000_0000);
		pulse(5'h04);
		repeat (3) @(posedge i_clk);
		`CHK("wd_rst_n", 1'b1, o_wd_rst_n)
		rd(`WDS_OFF_SUP_STAT_A, 32'h0000_0077, 32'h0000_0032);
		wr(`WDS_OFF_SUP_CFG, 32'h0000_0001);
		repeat (6) pulse(5'h04);
		rd(`WDS_OFF_SUP_STAT_A, 32'h0000_0077, 32'h0000_0077);
		`CHK("power_down", 1'b1, o_power_down)
		i_key <= 1'b1;
		repeat (3) @(posedge i_clk);
		`CHK("power_down", 1'b0, o_power_down)
		await(1'b1);
		// 33 is the first safe count, 32 still ready
		i_window_error_count <= 6'h21;
		repeat (4) @(posedge i_clk);
		`CHK("actuator_off", 1'b1, o_actuator_off)
		`CHK("safety_ok", 1'b0, o_safety_ok_pin)
		rd(`WDS_OFF_SUP_STAT_B, 32'h0000_0300, 32'h0000_0200);
		i_window_error_count <= 6'h20;
		repeat (4) @(posedge i_clk);
		`CHK("safety_ok", 1'b1, o_safety_ok_pin)
		rd(`WDS_OFF_SUP_STAT_A, 32'h0000_0077, 32'h0000_0007);
		wr(`WDS_OFF_HB_CFG, 32'h0000_0005);
		wr(`WDS_OFF_HB_CFG, 32'h0000_0000);
		rd(`WDS_OFF_HB_CFG, 32'hFFFF_FFFF, 32'h0000_0005);
		host.sample(q, h);
		`CHK("pre_sample", 1'b1, q < 32'h0000_0010)
		`CHK("hb_sample_range", 1'b1, h < 32'h0000_0005)
		`CHK("hb_sample", 25'h000_0000, h[31:7])
		give_verdict();
	end
endmodule : wds_top_bench
